// File: shared/rxo_pkg.sv
// Package with register map, field layout, codes and counts of the receive output block
package rxo_pkg;

  // ***********************************************************
  // Register map (byte addresses, one aligned word each)
  // ***********************************************************
  localparam logic [4:0] RXO_OFF_CTRL     = 5'h00;
  localparam logic [4:0] RXO_OFF_STATE    = 5'h04;
  localparam logic [4:0] RXO_OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] RXO_OFF_IRQ_EN   = 5'h0c;
  localparam logic [4:0] RXO_OFF_IRQ_CLR  = 5'h10;

  // ***********************************************************
  // Control register fields and reset value
  // ***********************************************************
  localparam int RXO_CTRL_PAR_LSB  = 0;   // parity_select, 2 bits
  localparam int RXO_CTRL_DEC_LSB  = 2;   // decoder_mode_select, 2 bits
  localparam int RXO_CTRL_ENC_LSB  = 4;   // status_encoding_select, 2 bits
  localparam int RXO_CTRL_CKS_LSB  = 6;   // rx_clock_select, 2 bits
  localparam int RXO_CTRL_BIST_BIT = 8;   // self-test compare enable
  localparam int RXO_CTRL_WIDTH    = 9;
  localparam logic [8:0] RXO_CTRL_RESET = 9'h000;

  // Three-level select codes: LOW, MID, HIGH
  localparam logic [1:0] RXO_LVL_LOW  = 2'h0;
  localparam logic [1:0] RXO_LVL_MID  = 2'h2;
  localparam logic [1:0] RXO_LVL_HIGH = 2'h3;

  // ***********************************************************
  // Interrupt bits
  // ***********************************************************
  localparam int RXO_IRQ_LOCK_LOSS = 0;
  localparam int RXO_IRQ_EBUF      = 1;
  localparam int RXO_IRQ_MISMATCH  = 2;
  localparam int RXO_IRQ_LAST_GOOD = 3;
  localparam int RXO_IRQ_LAST_BAD  = 4;
  localparam int RXO_IRQ_WIDTH     = 5;

  // ***********************************************************
  // Status codes
  // ***********************************************************
  localparam logic [2:0] RXO_ST_DATA      = 3'h0;
  localparam logic [2:0] RXO_ST_SPECIAL   = 3'h1;
  localparam logic [2:0] RXO_ST_EBUF      = 3'h2;
  localparam logic [2:0] RXO_ST_FRAMING   = 3'h3;
  localparam logic [2:0] RXO_ST_CODE_VIOL = 3'h4;
  localparam logic [2:0] RXO_ST_PLL       = 3'h5;
  localparam logic [2:0] RXO_ST_DISPARITY = 3'h6;
  localparam logic [2:0] RXO_ST_SELFTEST_START_STATE = 3'h5;
  localparam logic [2:0] RXO_ST_BIST_WAIT  = 3'h7;
  localparam logic [2:0] RXO_ST_BIST_ERROR = 3'h6;
  localparam logic [2:0] RXO_ST_BIST_GOOD  = 3'h2;
  localparam logic [2:0] RXO_ST_BIST_BAD   = 3'h4;
  localparam logic [2:0] RXO_ST_BIST_DATA  = 3'h0;
  localparam logic [2:0] RXO_ST_BIST_CMD   = 3'h1;

  // ***********************************************************
  // Self-test counts
  // ***********************************************************
  localparam logic [4:0] RXO_ERR_LIMIT   = 5'h10;  // errors may lead matches by 16
  localparam logic [3:0] RXO_HOLD_CHARS  = 4'h9;   // re-centring time in characters
  localparam logic [7:0] RXO_SEQ_FIRST   = 8'h00;  // first character of a sequence

  // Self-test compare states
  typedef enum logic [2:0] {
    RXO_BS_START,
    RXO_BS_WAIT,
    RXO_BS_DATA,
    RXO_BS_CMD,
    RXO_BS_ERROR,
    RXO_BS_GOOD,
    RXO_BS_BAD
  } rxo_bist_state_t;

endpackage

// File: hdl/rxo_output.sv
// Receive output register, parity, character status and self-test tracking
//
// How it works
// - parity registered with data and status
// - parity is always odd
// - parity select LOW floats parity pin
// - MID with decoder: parity over data only
// - MID bypassed: data plus low status bits
// - HIGH: parity over data and status
// - bypass, no self-test: top status is framing flag
// - decoded characters carry three status bits
// - only highest-priority status is reported
// - encoding select picks type A or B
// - with decoder, self-test shows compare state on status
// - lock loss forces start state at once
// - errors over matches by 17 force wait
// - buffer error holds start nine characters
// - both link ends use same clock select
// - bypass shows raw character plus framing flag ORed with self-test error
// - self-test codes 101,111,110,010,100
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module rxo_output
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [4:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic            wb_ack_o,
  // From the receive path
  input  wire logic       char_valid_i,
  input  wire logic [7:0] dec_data_i,
  input  wire logic       dec_special_i,
  input  wire logic       dec_code_viol_i,
  input  wire logic       dec_disparity_err_i,
  input  wire logic [9:0] raw_char_i,
  input  wire logic       framing_char_flag_i,
  input  wire logic       pll_lock_i,
  input  wire logic       ebuf_error_i,
  input  wire logic       bist_match_i,
  input  wire logic       bist_command_i,
  input  wire logic       bist_seq_end_i,
  // Parallel output bus
  output logic      [7:0] rx_data_o,
  output logic      [2:0] rx_status_bus_o,
  output logic            rx_parity_out_o,
  output logic            rx_parity_oe_n_o,
  output logic            rx_strobe_o,
  output logic [1:0]      rx_clock_select_o,
  output logic            irq_o
);
  import rxo_pkg::*;

  // ***********************************************************
  // Control and interrupt registers
  // ***********************************************************
  logic [RXO_CTRL_WIDTH-1:0] ctrl_q;
  logic [RXO_IRQ_WIDTH-1:0]  irq_stat_q;
  logic [RXO_IRQ_WIDTH-1:0]  irq_en_q;
  logic [RXO_IRQ_WIDTH-1:0]  irq_evt;
  logic                      wb_req;
  logic                      wb_wr;
  logic                      wb_ack_q;
  logic [31:0]               wb_dat_q;

  logic [1:0] parity_select;
  logic [1:0] decoder_mode_select;
  logic [1:0] status_encoding_select;
  logic       selftest_en;
  logic       bypass;

  assign parity_select          = ctrl_q[RXO_CTRL_PAR_LSB +: 2];
  assign decoder_mode_select    = ctrl_q[RXO_CTRL_DEC_LSB +: 2];
  assign status_encoding_select = ctrl_q[RXO_CTRL_ENC_LSB +: 2];
  assign selftest_en            = ctrl_q[RXO_CTRL_BIST_BIT];
  assign bypass                 = (decoder_mode_select == RXO_LVL_LOW);

  // The partner must use the same clock select, so it is published on a pin
  assign rx_clock_select_o = ctrl_q[RXO_CTRL_CKS_LSB +: 2];

  // One request is answered one cycle later; ack drops the cycle after
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  // Writes land at the edge where the master samples ack, never earlier
  assign wb_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_q;
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // Control register, byte lanes 0 and 1 carry its bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= RXO_CTRL_RESET;
    else if (wb_wr && wb_adr_i == RXO_OFF_CTRL)
    begin
      if (wb_sel_i[0])
        ctrl_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        ctrl_q[8] <= wb_dat_i[8];
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en_q <= '0;
    else if (wb_wr && wb_adr_i == RXO_OFF_IRQ_EN && wb_sel_i[0])
      irq_en_q <= wb_dat_i[RXO_IRQ_WIDTH-1:0];
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_q <= '0;
    else if (wb_wr && wb_adr_i == RXO_OFF_IRQ_CLR && wb_sel_i[0])
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[RXO_IRQ_WIDTH-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end

  // Level interrupt, high while any enabled bit is set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_q & irq_en_q);
  end

  // ***********************************************************
  // Self-test compare state machine
  // ***********************************************************
  rxo_bist_state_t bist_q;
  rxo_bist_state_t bist_d;
  logic [4:0]      diff_q;
  logic [4:0]      diff_d;
  logic [3:0]      hold_q;
  logic            seq_bad_q;
  logic            seq_bad_d;
  logic            lock_q;
  logic            is_seq_first;

  assign is_seq_first = (dec_data_i == RXO_SEQ_FIRST) & ~dec_special_i;

  // Next state; the lead of errors over matches is kept in diff
  always_comb
  begin
    bist_d    = bist_q;
    diff_d    = diff_q;
    seq_bad_d = seq_bad_q;
    if (char_valid_i)
    begin
      case (bist_q)
        RXO_BS_START:
        begin
          diff_d    = 5'h00;
          seq_bad_d = 1'b0;
          if (hold_q == 4'h0 && !ebuf_error_i)
            bist_d = RXO_BS_WAIT;
        end
        RXO_BS_WAIT:
        begin
          diff_d    = 5'h00;
          seq_bad_d = 1'b0;
          if (is_seq_first)
            bist_d = RXO_BS_DATA;
        end
        RXO_BS_DATA, RXO_BS_CMD, RXO_BS_ERROR, RXO_BS_GOOD, RXO_BS_BAD:
        begin
          if (bist_q == RXO_BS_GOOD || bist_q == RXO_BS_BAD)
            seq_bad_d = 1'b0;  // A new sequence starts clean
          if (bist_match_i)
          begin
            if (diff_q != 5'h00)
              diff_d = diff_q - 5'h01;
            if (bist_seq_end_i)
              bist_d = (seq_bad_d) ? RXO_BS_BAD : RXO_BS_GOOD;
            else
              bist_d = (bist_command_i) ? RXO_BS_CMD : RXO_BS_DATA;
          end
          else
          begin
            seq_bad_d = 1'b1;
            bist_d    = (bist_seq_end_i) ? RXO_BS_BAD : RXO_BS_ERROR;
            if (diff_q == RXO_ERR_LIMIT)
            begin
              // A 17th unmatched error: resynchronise on the next sequence
              bist_d = RXO_BS_WAIT;
              diff_d = 5'h00;
            end
            else
              diff_d = diff_q + 5'h01;
          end
        end
        default:
          bist_d = RXO_BS_START;
      endcase
      if (ebuf_error_i)
        bist_d = RXO_BS_START;
    end
    if (!pll_lock_i || !selftest_en)
      bist_d = RXO_BS_START;
  end

  // State register; lock loss acts on the clock, not on a character
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bist_q    <= RXO_BS_START;
      diff_q    <= 5'h00;
      seq_bad_q <= 1'b0;
    end
    else
    begin
      bist_q    <= bist_d;
      diff_q    <= diff_d;
      seq_bad_q <= seq_bad_d;
    end
  end

  // Characters left before the elasticity buffer counts as re-centred
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_q <= 4'h0;
    else if (char_valid_i && ebuf_error_i)
      hold_q <= RXO_HOLD_CHARS;
    else if (char_valid_i && hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end

  // Lock history for the lock-loss event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_q <= 1'b1;
    else
      lock_q <= pll_lock_i;
  end

  // Events into the sticky status register
  always_comb
  begin
    irq_evt = '0;
    irq_evt[RXO_IRQ_LOCK_LOSS] = lock_q & ~pll_lock_i;
    irq_evt[RXO_IRQ_EBUF]      = char_valid_i & ebuf_error_i;
    irq_evt[RXO_IRQ_MISMATCH]  = char_valid_i & bist_d == RXO_BS_ERROR & bist_q != RXO_BS_ERROR;
    irq_evt[RXO_IRQ_LAST_GOOD] = char_valid_i & bist_d == RXO_BS_GOOD;
    irq_evt[RXO_IRQ_LAST_BAD]  = char_valid_i & bist_d == RXO_BS_BAD;
  end

  // ***********************************************************
  // Character status encoding
  // ***********************************************************
  logic [2:0] bist_code;
  logic [2:0] norm_code;
  logic [7:0] data_d;
  logic [2:0] status_d;
  logic       parity_d;

  // Self-test state to status code
  always_comb
  begin
    case (bist_d)
      RXO_BS_START: bist_code = RXO_ST_SELFTEST_START_STATE;
      RXO_BS_WAIT:  bist_code = RXO_ST_BIST_WAIT;
      RXO_BS_ERROR: bist_code = RXO_ST_BIST_ERROR;
      RXO_BS_GOOD:  bist_code = RXO_ST_BIST_GOOD;
      RXO_BS_BAD:   bist_code = RXO_ST_BIST_BAD;
      RXO_BS_CMD:   bist_code = RXO_ST_BIST_CMD;
      RXO_BS_DATA:  bist_code = RXO_ST_BIST_DATA;
      default:      bist_code = RXO_ST_SELFTEST_START_STATE;
    endcase
  end

  // Normal status, highest priority first; type B folds framing into special
  always_comb
  begin
    if (!pll_lock_i)
      norm_code = RXO_ST_PLL;
    else if (ebuf_error_i)
      norm_code = RXO_ST_EBUF;
    else if (dec_code_viol_i)
      norm_code = RXO_ST_CODE_VIOL;
    else if (framing_char_flag_i)
      norm_code = (status_encoding_select == RXO_LVL_HIGH) ? RXO_ST_SPECIAL
                                                           : RXO_ST_FRAMING;
    else if (dec_disparity_err_i)
      norm_code = RXO_ST_DISPARITY;
    else if (dec_special_i)
      norm_code = RXO_ST_SPECIAL;
    else
      norm_code = RXO_ST_DATA;
  end

  // Output word and its parity, formed from the same next values
  always_comb
  begin
    if (bypass)
    begin
      // Raw character: a,b on status[1:0], c..j on the data bus
      data_d      = raw_char_i[9:2];
      status_d[0] = raw_char_i[1];
      status_d[1] = raw_char_i[0];
      if (selftest_en)
        status_d[2] = (bist_d == RXO_BS_ERROR) | framing_char_flag_i;
      else
        status_d[2] = framing_char_flag_i;
    end
    else
    begin
      data_d   = dec_data_i;
      status_d = (selftest_en) ? bist_code : norm_code;
    end
    case (parity_select)
      RXO_LVL_HIGH: parity_d = ~(^{data_d, status_d});
      RXO_LVL_MID:
        if (bypass)
          parity_d = ~(^{data_d, status_d[1:0]});
        else
          parity_d = ~(^data_d);
      default:      parity_d = 1'b0;
    endcase
  end

  // ***********************************************************
  // Output register stage
  // ***********************************************************
  // Data, status and parity load together so parity never lags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_data_o       <= 8'h00;
      rx_status_bus_o <= 3'h0;
      rx_parity_out_o <= 1'b0;
    end
    else
    begin
      if (char_valid_i)
      begin
        rx_data_o       <= data_d;
        rx_status_bus_o <= status_d;
        rx_parity_out_o <= parity_d;
      end
      // A floated pin must not keep a stale parity value behind it
      if (parity_select == RXO_LVL_LOW)
        rx_parity_out_o <= 1'b0;
    end
  end

  // Parity driver enable, low while driving; follows the select directly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_parity_oe_n_o <= 1'b1;
    else
      rx_parity_oe_n_o <= (parity_select == RXO_LVL_LOW);
  end

  // One-cycle strobe marking a new word on the output bus
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_strobe_o <= 1'b0;
    else
      rx_strobe_o <= char_valid_i;
  end

  // ***********************************************************
  // Wishbone read path and acknowledge
  // ***********************************************************
  // Unmapped addresses and the write-only clear register read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          RXO_OFF_CTRL:     wb_dat_q <= {23'h0, ctrl_q};
          RXO_OFF_STATE:    wb_dat_q <= {16'h0, diff_q, bist_code,
                                         3'h0, pll_lock_i, hold_q};
          RXO_OFF_IRQ_STAT: wb_dat_q <= {27'h0, irq_stat_q};
          RXO_OFF_IRQ_EN:   wb_dat_q <= {27'h0, irq_en_q};
          default:          wb_dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// File: testbench/rxo_output_asserts.sv
// Port-level checker of the receive output block
`timescale 1ns/100ps
module rxo_output_asserts
  import rxo_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        char_valid_i,
  input wire logic [9:0]  raw_char_i,
  input wire logic        framing_char_flag_i,
  input wire logic        pll_lock_i,
  input wire logic [7:0]  rx_data_o,
  input wire logic [2:0]  rx_status_bus_o,
  input wire logic        rx_parity_out_o,
  input wire logic        rx_parity_oe_n_o,
  input wire logic        rx_strobe_o,
  input wire logic        irq_o
);
  // ***********************************************************
  // Shadow of the control fields
  // ***********************************************************
  logic [1:0] par_q;
  logic [1:0] dec_q;
  logic       bist_q;
  logic       dec_on;
  assign dec_on = dec_q != RXO_LVL_LOW;
  // Tracks acknowledged writes; the word seen at a strobe uses these fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      par_q  <= RXO_LVL_LOW;
      dec_q  <= RXO_LVL_LOW;
      bist_q <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && wb_adr_i == RXO_OFF_CTRL && wb_sel_i[1:0] == 2'h3)
    begin
      par_q  <= wb_dat_i[1:0];
      dec_q  <= wb_dat_i[3:2];
      bist_q <= wb_dat_i[8];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  load_word_a: assert property (char_valid_i |=> rx_strobe_o)
    else $error("output word not loaded one cycle after a character");
  par_high_a: assert property (rx_strobe_o && par_q == RXO_LVL_HIGH
    |-> ^{rx_data_o, rx_status_bus_o, rx_parity_out_o})
    else $error("parity over data and all status is not odd");
  par_dec_a: assert property (rx_strobe_o && par_q == RXO_LVL_MID && dec_on
    |-> ^{rx_data_o, rx_parity_out_o})
    else $error("parity over decoded data is not odd");
  par_raw_a: assert property (rx_strobe_o && par_q == RXO_LVL_MID && !dec_on
    |-> ^{rx_data_o, rx_status_bus_o[1:0], rx_parity_out_o})
    else $error("parity over raw character is not odd");
  par_float_a: assert property ($stable(par_q)
    |-> rx_parity_oe_n_o == (par_q == RXO_LVL_LOW))
    else $error("parity pin enable does not follow the select");
  float_quiet_a: assert property (rx_parity_oe_n_o |-> !rx_parity_out_o)
    else $error("parity value present while pin floats");
  raw_map_a: assert property (rx_strobe_o && !dec_on && !bist_q
    |-> rx_data_o == $past(raw_char_i[9:2]) && rx_status_bus_o ==
    {$past(framing_char_flag_i), $past(raw_char_i[0]), $past(raw_char_i[1])})
    else $error("raw character mapping wrong in bypass");
  lock_start_a: assert property (rx_strobe_o && dec_on && !$past(pll_lock_i)
    |-> rx_status_bus_o == RXO_ST_PLL)
    else $error("lock loss not reported as start code");
  reset_idle_a: assert property ($fell(rst_i)
    |-> rx_parity_oe_n_o && rx_status_bus_o == 3'h0 && !irq_o && !rx_strobe_o)
    else $error("outputs not idle after reset");
endmodule

bind rxo_output rxo_output_asserts u_chk (.clk_i, .rst_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .char_valid_i, .raw_char_i, .framing_char_flag_i,
  .pll_lock_i, .rx_data_o, .rx_status_bus_o, .rx_parity_out_o, .rx_parity_oe_n_o,
  .rx_strobe_o, .irq_o);

// File: testbench/rxo_host_model.sv
// Host-side model that captures each receive output word
`timescale 1ns/100ps
module rxo_host_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_strobe_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [2:0]  rx_status_i,
  input  wire logic        rx_parity_i,
  input  wire logic        rx_parity_oe_n_i,
  output logic      [12:0] word_o
);
  logic pin_w;
  // Host pulls the floating parity pin low, so a stale value never shows
  assign pin_w = rx_parity_oe_n_i ? 1'b0 : rx_parity_i;
  // Data, status and parity taken on one strobe as one word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      word_o <= 13'h0000;
    else if (rx_strobe_i)
      word_o <= {rx_parity_oe_n_i, pin_w, rx_status_i, rx_data_i};
  end
endmodule

// File: testbench/rxo_output_tb_top.sv
// Self-checking bench of the receive output block
`timescale 1ns/100ps
module rxo_output_tb_top;
  import rxo_pkg::*;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        cv = 1'b0;
  logic [7:0]  dd = 8'h00;
  logic [9:0]  raw = 10'h000;
  logic [6:0]  fl = 7'h00;
  logic        lock = 1'b1;
  logic [7:0]  rxd;
  logic [2:0]  rxs;
  logic        rxp;
  logic        oen;
  logic        strb;
  logic [1:0]  cks;
  logic        irq;
  logic [12:0] word;
  logic [1:0]  par_m;
  logic [1:0]  dec_m;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [6:0]  fls [6] = '{7'h01, 7'h06, 7'h05, 7'h08, 7'h42, 7'h00};
  logic [2:0]  sts [6] = '{RXO_ST_SPECIAL, RXO_ST_CODE_VIOL, RXO_ST_DISPARITY,
                           RXO_ST_FRAMING, RXO_ST_EBUF, RXO_ST_DATA};

  // Character flags: 0 special, 1 code, 2 disparity, 3 framing, 4 match, 5 end, 6 ebuf
  rxo_output dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .char_valid_i(cv), .dec_data_i(dd), .dec_special_i(fl[0]),
    .dec_code_viol_i(fl[1]), .dec_disparity_err_i(fl[2]), .raw_char_i(raw),
    .framing_char_flag_i(fl[3]), .pll_lock_i(lock), .ebuf_error_i(fl[6]),
    .bist_match_i(fl[4]), .bist_command_i(1'b0), .bist_seq_end_i(fl[5]),
    .rx_data_o(rxd), .rx_status_bus_o(rxs), .rx_parity_out_o(rxp),
    .rx_parity_oe_n_o(oen), .rx_strobe_o(strb), .rx_clock_select_o(cks), .irq_o(irq));
  rxo_host_model host (.clk_i(clk_i), .rst_i(rst_i), .rx_strobe_i(strb), .rx_data_i(rxd),
    .rx_status_i(rxs), .rx_parity_i(rxp), .rx_parity_oe_n_i(oen), .word_o(word));

  // Clock of 8 ns
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cuts a hang short; the full run needs under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle held until ack is sampled high
  task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic setc(logic [1:0] p, logic [1:0] d, logic [1:0] e, logic b);
    par_m = p;
    dec_m = d;
    wb(1'b1, RXO_OFF_CTRL, {23'h0, b, RXO_LVL_MID, e, d, p});
  endtask

  // Expected host word; odd parity over the covered bits
  function automatic logic [12:0] wexp(logic [7:0] d, logic [2:0] s);
    logic p;
    p = ~^d;
    if (par_m == RXO_LVL_HIGH)
      p = ~^{d, s};
    else if (dec_m == RXO_LVL_LOW)
      p = ~^{d, s[1:0]};
    if (par_m == RXO_LVL_LOW)
      return {2'b10, s, d};
    return {1'b0, p, s, d};
  endfunction

  // One character in, then the captured word compared
  task automatic ch(logic [9:0] r, logic [6:0] f, logic [2:0] s);
    logic [7:0] d;
    d = r[7:0];
    if (dec_m == RXO_LVL_LOW)
    begin
      d = r[9:2];
      s = {f[3], r[0], r[1]};
    end
    @(posedge clk_i);
    cv  <= 1'b1;
    raw <= r;
    dd  <= r[7:0];
    fl  <= f;
    @(posedge clk_i);
    cv <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(word, wexp(d, s));
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({oen, rxs, irq}, 5'h10);
    rd(RXO_OFF_CTRL, 32'h0);
    rd(5'h14, 32'h0);
    $display("test reset done");
    setc(RXO_LVL_MID, RXO_LVL_LOW, RXO_LVL_LOW, 1'b0);
    ch(10'h2a5, 7'h00, 3'h0);
    ch(10'h17c, 7'h08, 3'h0);
    chk(cks, RXO_LVL_MID);
    setc(RXO_LVL_HIGH, RXO_LVL_LOW, RXO_LVL_LOW, 1'b0);
    ch(10'h3fe, 7'h08, 3'h0);
    ch(10'h000, 7'h00, 3'h0);
    $display("test bypass done");
    setc(RXO_LVL_MID, RXO_LVL_HIGH, RXO_LVL_LOW, 1'b0);
    for (int i = 0; i < 6; i++) ch(10'h0c3, fls[i], sts[i]);
    @(posedge clk_i) lock <= 1'b0;
    ch(10'h0c3, 7'h05, RXO_ST_PLL);
    @(posedge clk_i) lock <= 1'b1;
    setc(RXO_LVL_HIGH, RXO_LVL_HIGH, RXO_LVL_HIGH, 1'b0);
    ch(10'h000, 7'h08, RXO_ST_SPECIAL);
    setc(RXO_LVL_LOW, RXO_LVL_HIGH, RXO_LVL_LOW, 1'b0);
    ch(10'h081, 7'h00, RXO_ST_DATA);
    // The earlier buffer error still holds self-test at start; let it re-centre
    repeat (5) ch(10'h0c3, 7'h00, RXO_ST_DATA);
    $display("test decoded done");
    setc(RXO_LVL_MID, RXO_LVL_HIGH, RXO_LVL_LOW, 1'b1);
    ch(10'h055, 7'h00, RXO_ST_BIST_WAIT);
    ch(10'h000, 7'h10, RXO_ST_BIST_DATA);
    ch(10'h011, 7'h10, RXO_ST_BIST_DATA);
    ch(10'h022, 7'h30, RXO_ST_BIST_GOOD);
    @(posedge clk_i) lock <= 1'b0;
    ch(10'h033, 7'h10, RXO_ST_SELFTEST_START_STATE);
    @(posedge clk_i) lock <= 1'b1;
    ch(10'h033, 7'h00, RXO_ST_BIST_WAIT);
    ch(10'h000, 7'h10, RXO_ST_BIST_DATA);
    repeat (16) ch(10'h033, 7'h00, RXO_ST_BIST_ERROR);
    ch(10'h033, 7'h00, RXO_ST_BIST_WAIT);
    ch(10'h000, 7'h40, RXO_ST_SELFTEST_START_STATE);
    repeat (9) ch(10'h044, 7'h00, RXO_ST_SELFTEST_START_STATE);
    ch(10'h044, 7'h00, RXO_ST_BIST_WAIT);
    $display("test selftest done");
    wb(1'b1, RXO_OFF_IRQ_CLR, 32'h1f);
    rd(RXO_OFF_IRQ_STAT, 32'h0);
    wb(1'b1, RXO_OFF_IRQ_EN, 32'h1);
    @(posedge clk_i) lock <= 1'b0;
    @(posedge clk_i) lock <= 1'b1;
    rd(RXO_OFF_IRQ_STAT, 32'h1);
    #1;
    chk(irq, 32'h1);
    wb(1'b1, RXO_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq, 32'h0);
    wb(1'b1, RXO_OFF_IRQ_CLR, 32'h1);
    rd(RXO_OFF_IRQ_STAT, 32'h0);
    $display("test irq done");
    end_sim;
  end
endmodule
